// [verilog/dop_cmd_parser.sv]
// display-option command parser with apb status and address register
`timescale 1ns/1ps
module dop_cmd_parser
  import dop_pkg::*;
#(
  parameter int MSG_DEPTH = 32,
  parameter int MSG_AW    = 5
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  output logic                   rx_ready,
  output logic                   tx_valid,
  output logic      [7:0]        tx_data,
  input  wire logic              tx_ready,
  output dop_cfg_t               cfg,
  input  wire logic [MSG_AW-1:0] disp_rd_addr,
  output logic      [7:0]        disp_rd_data
);

  if (MSG_DEPTH < 2 || MSG_DEPTH != (1 << MSG_AW) || MSG_DEPTH >= (1 << LEN_W)) begin : g_chk
    $error("MSG_DEPTH must be a power of two equal to 2**MSG_AW and below 2**LEN_W");
  end

  dop_state_t       state_q;
  dop_kind_t        kind_q;
  logic [LEN_W-1:0] idx_q;
  logic [ACC_W-1:0] acc_q;
  logic             ch_q;
  logic [7:0]       p1_q;
  logic [7:0]       p2_q;
  logic             bad_q;
  logic [7:0]       com_addr_q;
  logic [1:0]       filt_type_q;
  logic [2:0]       filt_level_q;
  logic [2:0]       frac_q [2];
  logic [2:0]       code_q [2];
  dop_l2_mode_t     l2_mode_q;
  logic [LEN_W-1:0] msg_len_q;
  logic             tx_valid_q;
  logic [7:0]       tx_data_q;
  logic [31:0]      prdata_q;
  logic [7:0]       msg_rdata;
  logic             rx_fire;
  logic             is_cr;
  logic             cmd_ok;
  logic             commit;
  logic             tx_load;
  logic [7:0]       tx_byte;
  logic [5:0]       body_len;
  logic [3:0]       rx_dig;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_0) && (c <= CH_9);
  endfunction

  function automatic logic is_chan(input logic [7:0] c);
    return (c == CH_A) || (c == CH_B);
  endfunction

  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    return (a == REG_ADDR) || (a == REG_FILT) || (a == REG_CHAN) || (a == REG_LINE2);
  endfunction

  function automatic logic [7:0] mode_char(input dop_l2_mode_t m);
    case (m)
      L2_BLANK: return CH_B;
      L2_LIMIT: return CH_L;
      L2_DISP:  return CH_D;
      default:  return CH_T;
    endcase
  endfunction

  // two ascii digits of a step increment
  function automatic logic [7:0] step_tens(input logic [4:0] v);
    return dop_digit(4'(v / 5'd10));
  endfunction

  function automatic logic [7:0] step_units(input logic [4:0] v);
    return dop_digit(4'(v % 5'd10));
  endfunction

  assign rx_ready = (state_q != S_ACK) && (state_q != S_MRD) && (state_q != S_MTX)
                 && (state_q != S_CR) && (state_q != S_LF);
  assign rx_fire  = rx_valid && rx_ready;
  assign is_cr    = (rx_data == CH_CR);
  assign rx_dig   = 4'(rx_data - CH_0);

  // parameter range checks, evaluated at the terminating carriage return
  always_comb begin
    case (kind_q)
      K_VIEW:  cmd_ok = 1'b1;
      K_FILT:  cmd_ok = (p1_q >= CH_1) && (p1_q <= CH_2)
                     && (p2_q >= CH_1) && (p2_q <= CH_4);
      K_DEC:   cmd_ok = is_chan(p1_q) && (p2_q >= CH_0) && (p2_q <= CH_5);
      K_STEP:  cmd_ok = is_chan(p1_q) && (p2_q >= CH_0)
                     && (p2_q <= CH_0 + {5'h00, STEP_CODE_MAX});
      K_L2:    cmd_ok = (p1_q == CH_B) || (p1_q == CH_L)
                     || (p1_q == CH_D) || (p1_q == CH_T);
      default: cmd_ok = 1'b0;
    endcase
  end

  assign commit = rx_fire && (state_q == S_EOL) && is_cr && cmd_ok && !bad_q;

  // command framing and reply sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      kind_q  <= K_ERR;
      idx_q   <= '0;
      acc_q   <= '0;
      ch_q    <= 1'b0;
      p1_q    <= 8'h00;
      p2_q    <= 8'h00;
      bad_q   <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (rx_fire && rx_data == CH_AT) begin
            state_q <= S_ADDR;
            idx_q   <= '0;
            acc_q   <= '0;
            bad_q   <= 1'b0;
          end
        end
        S_ADDR: begin
          if (rx_fire) begin
            if (!is_digit(rx_data)) begin
              state_q <= is_cr ? S_IDLE : S_SKIP;
            end else begin
              acc_q <= ACC_W'(acc_q * DEC_TEN + {6'h00, rx_dig});
              idx_q <= idx_q + 1'b1;
              if (idx_q == LEN_W'(ADDR_DIGITS - 1)) begin
                state_q <= S_GROUP;
              end
            end
          end
        end
        S_GROUP: begin
          // other addresses and other command groups pass by silently
          if (rx_fire) begin
            if (acc_q == {2'b00, com_addr_q} && com_addr_q >= COM_ADDR_MIN
                && com_addr_q <= COM_ADDR_MAX && rx_data == CH_D) begin
              state_q <= S_SUB;
            end else begin
              state_q <= is_cr ? S_IDLE : S_SKIP;
            end
          end
        end
        S_SUB: begin
          if (rx_fire) begin
            idx_q   <= '0;
            state_q <= S_P1;
            case (rx_data)
              CH_V:    begin kind_q <= K_VIEW; state_q <= S_EOL; end
              CH_F:    kind_q <= K_FILT;
              CH_D:    kind_q <= K_DEC;
              CH_C:    kind_q <= K_STEP;
              CH_2:    kind_q <= K_L2;
              CH_T:    begin kind_q <= K_TEXT; state_q <= S_TEXT; end
              default: begin kind_q <= K_ERR; state_q <= is_cr ? S_ACK : S_EOL; end
            endcase
          end
        end
        S_P1: begin
          if (rx_fire) begin
            p1_q    <= rx_data;
            ch_q    <= (rx_data == CH_B);
            state_q <= (kind_q == K_L2) ? S_EOL : S_P2;
            if (is_cr) begin
              kind_q  <= K_ERR;
              state_q <= S_ACK;
            end
          end
        end
        S_P2: begin
          if (rx_fire) begin
            p2_q    <= rx_data;
            state_q <= S_EOL;
            if (is_cr) begin
              kind_q  <= K_ERR;
              state_q <= S_ACK;
            end
          end
        end
        S_EOL: begin
          if (rx_fire) begin
            if (is_cr) begin
              state_q <= S_ACK;
              if (!cmd_ok || bad_q) begin
                kind_q <= K_ERR;
              end
            end else begin
              bad_q <= 1'b1;
            end
          end
        end
        S_TEXT: begin
          if (rx_fire) begin
            if (is_cr) begin
              state_q <= S_ACK;
              idx_q   <= '0;
            end else if (idx_q < LEN_W'(MSG_DEPTH)) begin
              idx_q <= idx_q + 1'b1;
            end
          end
        end
        S_SKIP: begin
          if (rx_fire && is_cr) begin
            state_q <= S_IDLE;
          end
        end
        S_ACK: begin
          if (tx_load) begin
            idx_q <= idx_q + 1'b1;
            if (idx_q == PFX_LEN + body_len - 1'b1) begin
              idx_q   <= '0;
              state_q <= (kind_q == K_VIEW) ? S_MRD : S_CR;
            end
          end
        end
        S_MRD: state_q <= (idx_q >= msg_len_q) ? S_CR : S_MTX;
        S_MTX: begin
          if (tx_load) begin
            idx_q   <= idx_q + 1'b1;
            state_q <= S_MRD;
          end
        end
        S_CR: state_q <= tx_load ? S_LF : S_CR;
        // hold off the receiver until the line feed itself has been taken
        S_LF: state_q <= (tx_valid_q && tx_ready && tx_data_q == CH_LF) ? S_IDLE : S_LF;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // filter and line-two settings change only on an accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_type_q  <= RST_FILT_TYPE;
      filt_level_q <= RST_FILT_LEVEL;
      l2_mode_q    <= L2_BLANK;
    end else if (commit) begin
      if (kind_q == K_FILT) begin
        filt_type_q  <= 2'(p1_q - CH_0);
        filt_level_q <= 3'(p2_q - CH_0);
      end
      if (kind_q == K_L2) begin
        case (p1_q)
          CH_B:    l2_mode_q <= L2_BLANK;
          CH_L:    l2_mode_q <= L2_LIMIT;
          CH_D:    l2_mode_q <= L2_DISP;
          default: l2_mode_q <= L2_TEXT;
        endcase
      end
    end
  end

  // per-channel digits and step codes
  for (genvar g = 0; g < 2; g++) begin : g_chan
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        frac_q[g] <= RST_FRAC;
        code_q[g] <= RST_STEP_CODE;
      end else if (commit && ch_q == 1'(g)) begin
        if (kind_q == K_DEC) begin
          frac_q[g] <= 3'(p2_q - CH_0);
        end
        if (kind_q == K_STEP) begin
          code_q[g] <= 3'(p2_q - CH_0);
        end
      end
    end
  end

  // message length is committed when the text line ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_len_q <= '0;
    end else if (rx_fire && state_q == S_TEXT && is_cr) begin
      msg_len_q <= idx_q;
    end
  end

  // text is written as it arrives; a long string is cut at the store depth
  dop_msg_mem #(
    .DEPTH (MSG_DEPTH),
    .AW    (MSG_AW)
  ) u_mem (
    .clk     (pclk),
    .we      (rx_fire && state_q == S_TEXT && !is_cr && idx_q < LEN_W'(MSG_DEPTH)),
    .waddr   (MSG_AW'(idx_q)),
    .wdata   (rx_data),
    .raddr_a (MSG_AW'(idx_q)),
    .rdata_a (msg_rdata),
    .raddr_b (disp_rd_addr),
    .rdata_b (disp_rd_data)
  );

  always_comb begin
    case (kind_q)
      K_VIEW:  body_len = LEN_VIEW;
      K_FILT:  body_len = LEN_FILT;
      K_DEC:   body_len = LEN_DEC;
      K_STEP:  body_len = LEN_STEP;
      default: body_len = LEN_SHORT;
    endcase
  end

  // reply byte: address echo, then the resulting setting
  always_comb begin
    logic [5:0] b;
    logic [2:0] fr;
    logic [4:0] sv;
    b  = idx_q - PFX_LEN;
    fr = frac_q[ch_q];
    sv = dop_step_value(code_q[ch_q]);
    tx_byte = CH_SP;
    case (state_q)
      S_MTX:   tx_byte = msg_rdata;
      S_CR:    tx_byte = CH_CR;
      S_LF:    tx_byte = CH_LF;
      default: begin
        case (idx_q)
          6'h00: tx_byte = CH_AT;
          6'h02: tx_byte = dop_digit(4'(com_addr_q / 8'd100));
          6'h03: tx_byte = dop_digit(4'((com_addr_q / 8'd10) % 8'd10));
          6'h04: tx_byte = dop_digit(4'(com_addr_q % 8'd10));
          6'h01, 6'h05: tx_byte = CH_SP;
          default: begin
            case (kind_q)
              K_FILT: tx_byte = (b == 6'h00) ? CH_F : (b == 6'h01) ? CH_T
                             : (b == 6'h02) ? dop_digit({2'b00, filt_type_q})
                             : (b == 6'h03) ? CH_L : dop_digit({1'b0, filt_level_q});
              K_DEC:  tx_byte = (b == 6'h00) ? CH_C : (b == 6'h01) ? (ch_q ? CH_B : CH_A)
                             : (b == 6'h02) ? CH_D : dop_digit({1'b0, fr});
              K_STEP: tx_byte = (b == 6'h00) ? CH_C : (b == 6'h01) ? (ch_q ? CH_B : CH_A)
                             : (b == 6'h02) ? CH_S : (b == 6'h03) ? step_tens(sv)
                             : step_units(sv);
              K_L2:   tx_byte = (b == 6'h00) ? CH_L : (b == 6'h01) ? CH_2
                             : mode_char(l2_mode_q);
              K_TEXT: tx_byte = (b == 6'h00) ? CH_M : (b == 6'h01) ? CH_S : CH_G;
              K_ERR:  tx_byte = (b == 6'h00) ? CH_E : CH_R;
              default: begin
                case (b)
                  6'h00:   tx_byte = CH_F;
                  6'h01:   tx_byte = CH_T;
                  6'h02:   tx_byte = dop_digit({2'b00, filt_type_q});
                  6'h03:   tx_byte = CH_L;
                  6'h04:   tx_byte = dop_digit({1'b0, filt_level_q});
                  6'h05:   tx_byte = CH_A;
                  6'h06:   tx_byte = dop_digit({1'b0, frac_q[0]});
                  6'h07:   tx_byte = step_tens(dop_step_value(code_q[0]));
                  6'h08:   tx_byte = step_units(dop_step_value(code_q[0]));
                  6'h09:   tx_byte = CH_B;
                  6'h0a:   tx_byte = dop_digit({1'b0, frac_q[1]});
                  6'h0b:   tx_byte = step_tens(dop_step_value(code_q[1]));
                  6'h0c:   tx_byte = step_units(dop_step_value(code_q[1]));
                  6'h0d:   tx_byte = CH_M;
                  default: tx_byte = mode_char(l2_mode_q);
                endcase
              end
            endcase
          end
        endcase
      end
    endcase
  end

  // one byte in flight; a bubble between bytes keeps the sequencer simple
  assign tx_load = !tx_valid_q && (state_q == S_ACK || state_q == S_MTX
                                   || state_q == S_CR || state_q == S_LF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else if (tx_load) begin
      tx_valid_q <= 1'b1;
      tx_data_q  <= tx_byte;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data  = tx_data_q;

  // apb: zero wait states, read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_addr_q <= RST_COM_ADDR;
    end else if (psel && penable && pwrite && paddr == REG_ADDR) begin
      com_addr_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      case (paddr)
        REG_ADDR: prdata_q[7:0] <= com_addr_q;
        REG_FILT: begin
          prdata_q[F_TYPE_LSB +: 2]  <= filt_type_q;
          prdata_q[F_LEVEL_LSB +: 3] <= filt_level_q;
        end
        REG_CHAN: begin
          prdata_q[F_FRAC_LSB +: 3]            <= frac_q[0];
          prdata_q[F_CODE_LSB +: 3]            <= code_q[0];
          prdata_q[F_STEP_LSB +: 5]            <= dop_step_value(code_q[0]);
          prdata_q[F_CHAN_B + F_FRAC_LSB +: 3] <= frac_q[1];
          prdata_q[F_CHAN_B + F_CODE_LSB +: 3] <= code_q[1];
          prdata_q[F_CHAN_B + F_STEP_LSB +: 5] <= dop_step_value(code_q[1]);
        end
        REG_LINE2: begin
          prdata_q[F_MODE_LSB +: 2]    <= l2_mode_q;
          prdata_q[F_LEN_LSB +: LEN_W] <= msg_len_q;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  assign cfg = '{filt_type:  filt_type_q,
                 filt_level: filt_level_q,
                 frac_a:     frac_q[0],
                 frac_b:     frac_q[1],
                 step_a:     dop_step_value(code_q[0]),
                 step_b:     dop_step_value(code_q[1]),
                 l2_mode:    l2_mode_q,
                 msg_len:    msg_len_q};
endmodule

// [verilog/dop_pkg.sv]
// constants, types and helpers for the display-option command parser
// Functional notes
// - six subcommands recognised: view, filter, decimals, count step, line-two mode, line-two text
// - view reply reports filter, per-channel digits and steps, line-two mode and message
// - filter command carries type digit then level digit; type 1 or 2
// - chosen digit count drives fraction digits of that channel's load, peak, valley
// - count step command carries channel letter and one code digit for that channel
// - step codes map 0,1,2,3,4 to increments 1,2,5,10,20
// - line-two mode letter: B blank, L limit status, D display, T text
// - line-two text command stores the string as the line-two message
// - commands carry unit address 1 to 254; only own address answered
package dop_pkg;

  // ascii characters used by the parser and the replies
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0  = 8'h30;
  localparam logic [7:0] CH_1  = 8'h31;
  localparam logic [7:0] CH_2  = 8'h32;
  localparam logic [7:0] CH_4  = 8'h34;
  localparam logic [7:0] CH_5  = 8'h35;
  localparam logic [7:0] CH_9  = 8'h39;
  localparam logic [7:0] CH_A  = 8'h41;
  localparam logic [7:0] CH_B  = 8'h42;
  localparam logic [7:0] CH_C  = 8'h43;
  localparam logic [7:0] CH_D  = 8'h44;
  localparam logic [7:0] CH_E  = 8'h45;
  localparam logic [7:0] CH_F  = 8'h46;
  localparam logic [7:0] CH_G  = 8'h47;
  localparam logic [7:0] CH_L  = 8'h4c;
  localparam logic [7:0] CH_M  = 8'h4d;
  localparam logic [7:0] CH_R  = 8'h52;
  localparam logic [7:0] CH_S  = 8'h53;
  localparam logic [7:0] CH_T  = 8'h54;
  localparam logic [7:0] CH_V  = 8'h56;

  // unit address range and address digit parsing
  localparam logic [7:0] COM_ADDR_MIN = 8'h01;
  localparam logic [7:0] COM_ADDR_MAX = 8'hfe;
  localparam int         ADDR_DIGITS  = 3;
  localparam int         ACC_W        = 10;
  localparam logic [9:0] DEC_TEN      = 10'h00a;

  // count step table
  localparam logic [2:0] STEP_CODE_MAX = 3'h4;
  localparam logic [4:0] STEP_V0 = 5'h01;
  localparam logic [4:0] STEP_V1 = 5'h02;
  localparam logic [4:0] STEP_V2 = 5'h05;
  localparam logic [4:0] STEP_V3 = 5'h0a;
  localparam logic [4:0] STEP_V4 = 5'h14;

  // reset values
  localparam logic [7:0] RST_COM_ADDR   = 8'h01;
  localparam logic [1:0] RST_FILT_TYPE  = 2'h1;
  localparam logic [2:0] RST_FILT_LEVEL = 3'h1;
  localparam logic [2:0] RST_FRAC       = 3'h5;
  localparam logic [2:0] RST_STEP_CODE  = 3'h0;

  // apb register map, byte addresses
  localparam int          APB_AW    = 12;
  localparam logic [11:0] REG_ADDR  = 12'h000;
  localparam logic [11:0] REG_FILT  = 12'h004;
  localparam logic [11:0] REG_CHAN  = 12'h008;
  localparam logic [11:0] REG_LINE2 = 12'h00c;

  // field positions inside the status words
  localparam int F_TYPE_LSB  = 0;
  localparam int F_LEVEL_LSB = 8;
  localparam int F_FRAC_LSB  = 0;
  localparam int F_CODE_LSB  = 4;
  localparam int F_STEP_LSB  = 8;
  localparam int F_CHAN_B    = 16;
  localparam int F_MODE_LSB  = 0;
  localparam int F_LEN_LSB   = 8;

  // reply layout: "@ nnn " prefix then a body per command
  localparam logic [5:0] PFX_LEN   = 6'h06;
  localparam logic [5:0] LEN_VIEW  = 6'h0f;
  localparam logic [5:0] LEN_FILT  = 6'h05;
  localparam logic [5:0] LEN_DEC   = 6'h04;
  localparam logic [5:0] LEN_STEP  = 6'h05;
  localparam logic [5:0] LEN_SHORT = 6'h03;

  localparam int LEN_W = 6;

  typedef enum logic [1:0] {
    L2_BLANK = 2'b00,
    L2_LIMIT = 2'b01,
    L2_DISP  = 2'b10,
    L2_TEXT  = 2'b11
  } dop_l2_mode_t;

  typedef enum logic [2:0] {
    K_VIEW = 3'b000,
    K_FILT = 3'b001,
    K_DEC  = 3'b010,
    K_STEP = 3'b011,
    K_L2   = 3'b100,
    K_TEXT = 3'b101,
    K_ERR  = 3'b110
  } dop_kind_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ADDR  = 4'b0001,
    S_GROUP = 4'b0010,
    S_SUB   = 4'b0011,
    S_P1    = 4'b0100,
    S_P2    = 4'b0101,
    S_EOL   = 4'b0110,
    S_TEXT  = 4'b0111,
    S_SKIP  = 4'b1000,
    S_ACK   = 4'b1001,
    S_MRD   = 4'b1010,
    S_MTX   = 4'b1011,
    S_CR    = 4'b1100,
    S_LF    = 4'b1101
  } dop_state_t;

  typedef struct packed {
    logic [1:0]       filt_type;
    logic [2:0]       filt_level;
    logic [2:0]       frac_a;
    logic [2:0]       frac_b;
    logic [4:0]       step_a;
    logic [4:0]       step_b;
    dop_l2_mode_t     l2_mode;
    logic [LEN_W-1:0] msg_len;
  } dop_cfg_t;

  function automatic logic [7:0] dop_digit(input logic [3:0] v);
    return CH_0 + {4'h0, v};
  endfunction

  function automatic logic [4:0] dop_step_value(input logic [2:0] code);
    case (code)
      3'h0:    return STEP_V0;
      3'h1:    return STEP_V1;
      3'h2:    return STEP_V2;
      3'h3:    return STEP_V3;
      default: return STEP_V4;
    endcase
  endfunction

endpackage

// [verilog/dop_msg_mem.sv]
// message store: one write port, two registered read ports
`timescale 1ns/1ps
module dop_msg_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [7:0]    rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [7:0]    rdata_b
);
  logic [7:0] mem [DEPTH];

  // no reset on the array so it maps onto block ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

// [testbench/dop_props.sv]
// assertion checker for the display-option command parser
`timescale 1ns/1ps
module dop_props
  import dop_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pslverr,
  input wire logic              rx_valid,
  input wire logic [7:0]        rx_data,
  input wire logic              rx_ready,
  input wire logic              tx_valid,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_ready,
  input wire dop_cfg_t          cfg
);
  logic cr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cr_q <= 1'b0;
    else cr_q <= rx_valid && rx_ready && (rx_data == CH_CR);
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tx_wait;
    tx_valid && !tx_ready;
  endsequence
  sequence s_apb_acc;
    psel && penable;
  endsequence
  a_tx_holds: assert property (s_tx_wait |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  a_rx_blocked: assert property (tx_valid |-> !rx_ready)
    else $error("rx taken during reply");
  a_cfg_at_cr: assert property ($changed(cfg) |-> cr_q)
    else $error("settings changed off a terminator");
  a_step_table: assert property (cfg.step_a inside {5'h01, 5'h02, 5'h05, 5'h0a, 5'h14})
    else $error("step value off table");
  a_frac_range: assert property (cfg.frac_a <= 3'h5 && cfg.frac_b <= 3'h5)
    else $error("digit count out of range");
  a_filt_range: assert property (cfg.filt_type inside {2'h1, 2'h2} && cfg.filt_level inside {[3'h1:3'h4]})
    else $error("filter setting out of range");
  a_slv_unmapped: assert property (s_apb_acc ##0 (paddr > REG_LINE2) |-> pslverr)
    else $error("unmapped access not refused");
  a_slv_mapped: assert property (s_apb_acc ##0 (paddr == REG_FILT) |-> !pslverr)
    else $error("mapped access refused");
endmodule
bind dop_cmd_parser dop_props i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cfg(cfg));

// [testbench/dop_host_model.sv]
// remote terminal model: sends command bytes, collects reply bytes
`timescale 1ns/1ps
module dop_host_model (
  input  wire logic       pclk,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  string rep = "";
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  // slow mode takes a byte every other cycle to stretch the reply
  always @(posedge pclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready) rep = {rep, string'(tx_data)};
  end
  task send(input string s);
    @(posedge pclk);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      @(posedge pclk);
      while (!rx_ready) @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~s[s.len()-1]; // idle line never repeats the last byte
  endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the display-option command parser
`timescale 1ns/1ps
module testbench;
  import dop_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rx_data, tx_data, disp_rd_data;
  logic [4:0]  disp_rd_addr;
  dop_cfg_t    cfg;
  int          mismatches, n_checks, cyc;
  string       s;
  typedef struct {string c; string r; logic [11:0] a; logic [31:0] v;} row_t;
  row_t rows [15] = '{'{"F13", "FT1L3", REG_FILT, 32'h301}, '{"F24", "FT2L4", REG_FILT, 32'h402},
    '{"F15", "ERR", REG_FILT, 32'h402}, '{"DA0", "CAD0", REG_CHAN, 32'h01050100},
    '{"DB6", "ERR", REG_CHAN, 32'h01050100}, '{"CA3", "CAS10", REG_CHAN, 32'h01050a30},
    '{"CB4", "CBS20", REG_CHAN, 32'h14450a30}, '{"CA5", "ERR", REG_CHAN, 32'h14450a30},
    '{"2T", "L2T", REG_LINE2, 32'h3}, '{"THI", "MSG", REG_LINE2, 32'h203},
    '{"2L", "L2L", REG_LINE2, 32'h201}, '{"2D", "L2D", REG_LINE2, 32'h202},
    '{"2B", "L2B", REG_LINE2, 32'h200}, '{"V", "FT2L4A010B520MBHI", REG_LINE2, 32'h200},
    '{"X", "ERR", REG_LINE2, 32'h200}};
  dop_cmd_parser i_dop_cmd_parser (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cfg(cfg),
    .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data));
  dop_host_model i_dop_host_model (.pclk(pclk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task chk_s(input string got, input string exp);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: reply mismatch, expected %s", $time, exp);
    end
  endtask
  // one transfer; response taken at the rising edge that sees pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    err = pslverr;
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // no reply leaves the wait to run its full bound
  task cmd(input string c);
    i_dop_host_model.rep = "";
    i_dop_host_model.send(c);
    s = i_dop_host_model.rep;
    for (int k = 0; k < 400 && (s.len() == 0 || s[s.len()-1] != CH_LF); k++) begin
      @(posedge pclk);
      s = i_dop_host_model.rep;
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slow, disp_rd_addr} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CHAN, 32'h0);
    chk_v(rd, 32'h01050105);
    foreach (rows[i]) begin
      slow <= i[0];
      cmd({"@001D", rows[i].c, "\r"});
      chk_s(s.substr(0, 5), "@ 001 ");
      chk_s(s, {"@ 001 ", rows[i].r, "\r\n"});
      apb(1'b0, rows[i].a, 32'h0);
      chk_v(rd, rows[i].v);
      $display("row %0d done", i);
    end
    repeat (2) @(posedge pclk);
    chk_v({24'h0, disp_rd_data}, {24'h0, CH_0 + 8'h18});
    cmd("@002DF11\r");
    chk_s(s, "");
    apb(1'b1, REG_ADDR, 32'h2);
    apb(1'b0, REG_ADDR, 32'h0);
    chk_v(rd, 32'h2);
    cmd("@002DF11\r");
    chk_s(s, "@ 002 FT1L1\r\n");
    apb(1'b0, 12'h010, 32'h0);
    chk_v({31'h0, err}, 32'h1);
    chk_v(rd, 32'h0);
    $display("address and refusal tests done");
    finish_test();
  end
endmodule
